//--- verilog/float_normalize_unit.sv
// Three-period normalize datapath with a small register port
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RL1: Negative operand: invert exponent bits 48 to 58 into biased positive form.
// RL2: Exponent low ten bits all ones means overflow/indefinite; withhold shift permit.
// RL3: Without shift permit, pass operand unchanged and write count zero.
// RL4: Forward operand sign bit 59 to the destination sign control.
// RL5: Round variant sets flag from m0; extra bit below coefficient shifts along.
// RL6: Second period: first exponent subtraction stage of count, gated, registered.
// RL7: Opcode 24 zero coefficient, count 48: block gating, underflow, zeros result.
// RL8: Exponent borrow past range blocks gating and signals underflow, zeros result.
// RL9: Hold launch strobe into third period; enables gating, zeros count bits 6-17.
// RL10: Held strobe, no permit: indefinite if exponent bit 10 clear, else infinite.
// RL11: Third period finishes exponent subtraction; exponent gated in inverted form.
// RL12: Capture coefficient bits 0-47 at issue; invert when sign bit is one.
// RL13: Combinational six-bit count of zeros above the topmost one through bit 47.
// RL14: Second period decodes count into shift controls; register controls and count.
// RL15: Count writeback gate writes six-bit count to count register bits 0-5.
// RL16: Rank one shifts left by one when count bit 0 and permit set.
// RL17: Third period ranks two to four finish; coefficient gated inverted.
// RL18: Issue logic holds instructions whose operand is still reserved as destination.
// RL19: Each instruction completes in three periods; operands taken at issue.
// RL20: Shift coefficient until bit 47 is one; reduce exponent by shift amount.
// RL21: Round variant with zero coefficient gives normalized result and count 48.
module float_normalize_unit (
    // Clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           rstn,
    // Launch from issue logic
    input  wire norm_pkg::launch_t              launch,
    // Results to destination registers
    output var  norm_pkg::result_t              res,
    // Register port
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [31:0]                    reg_rdata
);
    // Reset release
    logic                   rst_meta_ff;
    logic                   rst_n_ff;
    // Pipeline state
    norm_pkg::launch_t      in_ff;
    norm_pkg::launch_t      nxt_in;
    norm_pkg::stage2_t      st2_ff;
    norm_pkg::stage2_t      nxt_st2;
    norm_pkg::result_t      res_ff;
    norm_pkg::result_t      nxt_res;
    // Register file state
    logic                   en_ff;
    logic                   nxt_en;
    logic [3:0]             status_ff;
    logic [3:0]             nxt_status;
    logic [5:0]             lastcnt_ff;
    logic [5:0]             nxt_lastcnt;
    logic [31:0]            rdata_ff;
    logic [31:0]            nxt_rdata;
    // Second-period network signals
    logic [10:0]            exp_c;
    logic [47:0]            coef_c;
    logic                   permit_c;
    // Leading-one search chains
    logic [48:0]            one_above;
    logic [48:0][5:0]       cnt_chain;
    logic [5:0]             cnt_c;
    logic [5:0]             cnt_g;
    logic [6:0]             sub_lo;
    // Third-period network signals
    logic [48:0]            sh_a;
    logic [48:0]            sh_b;
    logic [48:0]            sh_c;
    logic [5:0]             sub_hi;
    logic                   underflow_c;
    logic                   gate_c;
    logic [59:0]            pos_word;

    // Reset release through two flops
    // Assertion stays asynchronous so outputs clear without a running clock
    // Release is synchronous so every stage leaves reset on the same edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // First period: take operands when the instruction issues
    // Idle cycles still load the operand; only the go bit marks real work
    // Clearing go while disabled keeps a refused launch out of later stages
    always_comb begin
        nxt_in    = launch;
        // RL19: capture at issue
        nxt_in.go = launch.go & en_ff;
    end

    // Input register stage
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            in_ff <= '0;
        end else begin
            in_ff <= nxt_in;
        end
    end

    // Sign correction and special-case test on the captured operand
    always_comb begin
        // RL1: sign-correct exponent
        exp_c  = in_ff.opnd[norm_pkg::EXP_HI:norm_pkg::EXP_LO] ^ {11{in_ff.opnd[norm_pkg::SIGN_BIT]}};
        // RL12: sign-correct coefficient
        coef_c = in_ff.opnd[norm_pkg::COEF_W-1:0] ^ {48{in_ff.opnd[norm_pkg::SIGN_BIT]}};
        // RL2: ones check withholds permit
        permit_c = ~(&exp_c[9:0]);
    end

    // RL13: per-bit search for the topmost one of the coefficient
    // A bit adds 47 minus its position only when no one sits above it
    assign one_above[norm_pkg::COEF_W] = 1'b0;
    assign cnt_chain[norm_pkg::COEF_W] = 6'h00;
    for (genvar gi = 0; gi < norm_pkg::COEF_W; gi++) begin : g_lzc
        logic top_here;
        assign top_here      = coef_c[gi] & ~one_above[gi+1];
        assign one_above[gi] = one_above[gi+1] | coef_c[gi];
        assign cnt_chain[gi] = cnt_chain[gi+1] | (top_here ? 6'(47 - gi) : 6'h00);
    end

    // Count gating and first exponent subtraction stage
    always_comb begin
        // RL13: all-zero coefficient counts every position
        cnt_c  = one_above[0] ? cnt_chain[0] : norm_pkg::ZERO_COEF_CNT;
        // RL6: count gated by permit before the adder
        cnt_g  = permit_c ? cnt_c : 6'h00;
        // Bit 6 of the difference is the borrow into the upper stage
        sub_lo = {1'b0, exp_c[5:0]} - {1'b0, cnt_g};
    end

    // Second period: decode, rank one, partial difference
    // Without permit every rank selects no shift, so a special operand
    // crosses the ranks untouched
    always_comb begin
        nxt_st2          = '0;
        nxt_st2.go       = in_ff.go;
        nxt_st2.permit   = permit_c;
        // RL5: round flag from m0
        nxt_st2.round    = in_ff.m0;
        nxt_st2.sign     = in_ff.opnd[norm_pkg::SIGN_BIT];
        nxt_st2.opnd     = in_ff.opnd;
        nxt_st2.exp10    = exp_c[10];
        nxt_st2.exp_hi   = exp_c[10:6];
        nxt_st2.diff_lo  = sub_lo[5:0];
        nxt_st2.borrow   = sub_lo[6];
        // RL14: decode and hold controls
        nxt_st2.cnt      = cnt_g;
        nxt_st2.no_shift = ~permit_c;
        nxt_st2.sh2      = permit_c & cnt_c[1];
        nxt_st2.r3_oh    = permit_c ? (4'h1 << cnt_c[3:2]) : 4'h1;
        nxt_st2.r4_oh    = permit_c ? (4'h1 << cnt_c[5:4]) : 4'h1;
        // RL16: rank one, round bit below bit 0
        nxt_st2.coef     = (permit_c & cnt_c[0]) ? {coef_c, in_ff.m0} << 1 : {coef_c, in_ff.m0};
    end

    // Second-period register stage
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            st2_ff <= '0;
        end else begin
            st2_ff <= nxt_st2;
        end
    end

    // Third period: ranks two to four and exponent completion
    // One-hot rank controls take at most one shift per rank
    // The round bit enters below bit 0 and shifts along; bit 0 of the shifted word drops out of the result
    always_comb begin
        // RL17: remaining shift ranks
        sh_a = st2_ff.sh2 ? st2_ff.coef << 2 : st2_ff.coef;
        sh_b = sh_a;
        if (st2_ff.r3_oh[1]) begin
            sh_b = sh_a << 4;
        end else if (st2_ff.r3_oh[2]) begin
            sh_b = sh_a << 8;
        end else if (st2_ff.r3_oh[3]) begin
            sh_b = sh_a << 12;
        end
        sh_c = sh_b;
        if (st2_ff.r4_oh[1]) begin
            sh_c = sh_b << 16;
        end else if (st2_ff.r4_oh[2]) begin
            sh_c = sh_b << 32;
        end else if (st2_ff.r4_oh[3]) begin
            sh_c = sh_b << 48;
        end
        // RL11: second subtraction stage
        sub_hi = {1'b0, st2_ff.exp_hi} - {5'h00, st2_ff.borrow};
        // A borrow past the top adder bit means the exponent fell below zero
        // RL8: borrow out means complete underflow
        underflow_c = st2_ff.permit & sub_hi[5];
        // RL7: zero coefficient without round
        // RL21: round bit exempts zero coefficient
        if (st2_ff.permit & ~st2_ff.round & (st2_ff.cnt == norm_pkg::ZERO_COEF_CNT)) begin
            underflow_c = 1'b1;
        end
        // RL9: held strobe enables gating
        gate_c = st2_ff.go & st2_ff.permit & ~underflow_c;
        // RL20: normalized word in positive form
        pos_word = {1'b0, sub_hi[4:0], st2_ff.diff_lo, sh_c[48:1]};
    end

    // Result assembly toward the destination registers
    always_comb begin
        nxt_res            = '0;
        nxt_res.result_we  = st2_ff.go;
        // RL4: sign control
        nxt_res.sign_ctl   = st2_ff.sign;
        // Blocked gate leaves zeros unless permit is withheld, as the destination sees on underflow
        if (gate_c) begin
            // RL11: inverted gate, sign control restores positives
            nxt_res.result = ~pos_word ^ {60{~st2_ff.sign}};
        end else if (st2_ff.go & st2_ff.no_shift) begin
            // RL3: pass through unaltered
            nxt_res.result = st2_ff.opnd;
        end
        // RL15: count writeback gate
        nxt_res.count_we   = st2_ff.go;
        // RL9: upper count bits zero; count stands only with its write
        if (st2_ff.go) begin
            nxt_res.count  = {12'h000, st2_ff.cnt};
        end
        nxt_res.underflow  = st2_ff.go & underflow_c;
        // Flags need the held strobe so idle cycles never raise them
        // RL10: exit-condition flags
        nxt_res.indefinite = st2_ff.go & ~st2_ff.exp10 & ~st2_ff.permit;
        nxt_res.infinite   = st2_ff.go & st2_ff.exp10 & ~st2_ff.permit;
    end

    // Result register stage
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            res_ff <= '0;
        end else begin
            res_ff <= nxt_res;
        end
    end

    // Outputs come straight from flops
    assign res = res_ff;

    // Register writes, status capture and read mux
    always_comb begin
        nxt_en      = en_ff;
        nxt_status  = status_ff;
        nxt_lastcnt = lastcnt_ff;
        nxt_rdata   = 32'h0000_0000;
        if (reg_wr && reg_addr == norm_pkg::CTRL_OFS) begin
            nxt_en = reg_wdata[norm_pkg::CTRL_EN_BIT];
        end
        // Status follows each completed launch; software sees the last one
        if (nxt_res.result_we) begin
            nxt_status[norm_pkg::ST_INDEF_BIT] = nxt_res.indefinite;
            nxt_status[norm_pkg::ST_INF_BIT]   = nxt_res.infinite;
            nxt_status[norm_pkg::ST_UNDER_BIT] = nxt_res.underflow;
            nxt_lastcnt = nxt_res.count[5:0];
        end
        // Busy covers both internal stages of a launch in flight
        nxt_status[norm_pkg::ST_BUSY_BIT] = in_ff.go | st2_ff.go;
        // Read data is zero outside the answer cycle
        if (reg_rd) begin
            if (reg_addr == norm_pkg::CTRL_OFS) begin
                nxt_rdata[norm_pkg::CTRL_EN_BIT] = en_ff;
            end else if (reg_addr == norm_pkg::STATUS_OFS) begin
                nxt_rdata[3:0] = status_ff;
            end else if (reg_addr == norm_pkg::COUNT_OFS) begin
                nxt_rdata[5:0] = lastcnt_ff;
            end
        end
    end

    // Register file state; enable comes up set so no set-up write is needed
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            en_ff      <= norm_pkg::CTRL_EN_RST;
            status_ff  <= 4'h0;
            lastcnt_ff <= 6'h00;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            en_ff      <= nxt_en;
            status_ff  <= nxt_status;
            lastcnt_ff <= nxt_lastcnt;
            rdata_ff   <= nxt_rdata;
        end
    end

    // Read answer straight from its flop
    assign reg_rdata = rdata_ff;
endmodule

`default_nettype wire

//--- verilog/norm_pkg.sv
// Constants and carrier types for the floating-point normalize datapath
package norm_pkg;
    // Operand layout
    localparam int WORD_W    = 60;
    localparam int COEF_W    = 48;
    localparam int EXP_W     = 11;
    localparam int CNT_W     = 6;
    localparam int CNTREG_W  = 18;
    localparam int SIGN_BIT  = 59;
    localparam int EXP_LO    = 48;
    localparam int EXP_HI    = 58;
    localparam int CNT_EXT_LO = 6;
    // Count of an all-zero coefficient
    localparam logic [5:0] ZERO_COEF_CNT = 6'h30;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS  = 8'h08;
    // Register fields and reset values
    localparam int CTRL_EN_BIT        = 0;
    localparam logic CTRL_EN_RST      = 1'b1;
    localparam int ST_INDEF_BIT       = 0;
    localparam int ST_INF_BIT         = 1;
    localparam int ST_UNDER_BIT       = 2;
    localparam int ST_BUSY_BIT        = 3;

    // Launch request from the issue logic
    typedef struct packed {
        logic              go;
        logic              m0;
        logic [WORD_W-1:0] opnd;
    } launch_t;

    // Second-period results held for the third period
    typedef struct packed {
        logic              go;
        logic              permit;
        logic              round;
        logic              sign;
        logic [WORD_W-1:0] opnd;
        logic              exp10;
        logic [4:0]        exp_hi;
        logic [5:0]        diff_lo;
        logic              borrow;
        logic [CNT_W-1:0]  cnt;
        logic              sh2;
        logic [3:0]        r3_oh;
        logic [3:0]        r4_oh;
        logic              no_shift;
        logic [COEF_W:0]   coef;
    } stage2_t;

    // Results for the destination registers and exit-condition logic
    typedef struct packed {
        logic                result_we;
        logic [WORD_W-1:0]   result;
        logic                sign_ctl;
        logic                count_we;
        logic [CNTREG_W-1:0] count;
        logic                underflow;
        logic                indefinite;
        logic                infinite;
    } result_t;
endpackage

//--- sim/issue_model.sv
// Issue logic model that launches normalize instructions
`timescale 1ns/1ns
`default_nettype none
module issue_model (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // Requests from the bench
    input  wire logic              issue,
    input  wire logic              m0,
    input  wire logic [59:0]       word,
    input  wire logic              reserved,
    // Launch toward the unit
    output var  norm_pkg::launch_t launch
);
    // Launch register; idle lanes toggle so stale data never looks valid
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            launch <= '0;
        end else begin
            launch.go   <= issue && !reserved;
            launch.m0   <= (issue && !reserved) ? m0 : ~launch.m0;
            launch.opnd <= (issue && !reserved) ? word : ~launch.opnd;
        end
    end
endmodule
`default_nettype wire

//--- sim/float_normalize_monitor.sv
// Port checker for the normalize datapath
`timescale 1ns/1ns
`default_nettype none
module float_normalize_monitor (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // Datapath
    input  wire norm_pkg::launch_t launch,
    input  wire norm_pkg::result_t res,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [31:0]       reg_rdata
);
    logic spec;
    // Corrected exponent low ten bits all ones
    assign spec = &(launch.opnd[57:48] ^ {10{launch.opnd[59]}});
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_result_three_late: assert property (res.result_we |-> $past(launch.go, 3))
        else $error("result without launch three cycles before");
    a_count_pairs: assert property (res.count_we == res.result_we)
        else $error("count write not paired with result");
    a_idle_zero: assert property (!res.result_we |-> res.result == 60'h0 && res.count == 18'h0_0000)
        else $error("result or count not zero outside the write cycle");
    a_count_ext_zero: assert property (res.count_we |-> res.count[17:6] == 12'h000)
        else $error("count upper bits not zero");
    a_sign_forward: assert property (res.result_we |-> res.sign_ctl == $past(launch.opnd[59], 3))
        else $error("sign control differs from operand sign");
    a_special_pass: assert property (res.result_we && $past(spec, 3) |->
        res.result == $past(launch.opnd, 3) && res.count == 18'h0_0000 && (res.indefinite ^ res.infinite))
        else $error("special operand not passed through");
    a_under_zero: assert property (res.underflow |-> res.result_we && res.result == 60'h0)
        else $error("underflow result not zero");
    a_count_range: assert property (res.count_we |-> res.count[5:0] <= 6'h30)
        else $error("count above forty-eight");
    a_norm_top: assert property (res.result_we && !res.underflow && !$past(spec, 3) |->
        res.result[47] != res.result[59])
        else $error("result coefficient not normalized");
    a_rdata_idle: assert property (reg_rdata != 32'h0000_0000 |-> $past(reg_rd))
        else $error("read data outside read answer cycle");
    // Main scenarios
    cover property (res.underflow);
    cover property (res.indefinite);
    cover property (res.infinite);
    cover property (reg_rd ##1 reg_rdata != 32'h0000_0000);
endmodule
bind float_normalize_unit float_normalize_monitor float_normalize_monitor_inst (.clk_sys(clk_sys), .rstn(rstn),
    .launch(launch), .res(res), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the normalize datapath
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic              clk_sys   = 1'b0;
    logic              rstn      = 1'b0;
    logic              issue     = 1'b0;
    logic              m0_r      = 1'b0;
    logic [59:0]       word_r    = 60'h0;
    logic              reserved  = 1'b0;
    logic [7:0]        reg_addr  = 8'h00;
    logic [31:0]       reg_wdata = 32'h0000_0000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [31:0]       reg_rdata;
    norm_pkg::launch_t launch;
    norm_pkg::result_t res;
    int                n_errors   = 0;
    int                num_checks = 0;
    int                cyc        = 0;
    logic [63:0]       vec [10]   = '{64'h0400_0000_0000_1234, 64'h1BFF_FFFF_FFFF_EDCB, 64'h0400_8000_0000_0000,
        64'h13FF_0000_0000_0001, 64'h07FF_8000_0000_0000, 64'h0C00_FFFF_FFFF_FFFE, 64'h0400_0000_0000_0000,
        64'h1400_0000_0000_0000, 64'h0005_0000_0000_0001, 64'h1030_0000_0000_0001};
    // Clock, 8 ns period
    always #4 clk_sys = ~clk_sys;
    issue_model issue_model_inst (.clk_sys(clk_sys), .rstn(rstn), .issue(issue), .m0(m0_r), .word(word_r),
        .reserved(reserved), .launch(launch));
    float_normalize_unit float_normalize_unit_inst (.clk_sys(clk_sys), .rstn(rstn), .launch(launch), .res(res),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Expected outputs of one launch
    function automatic norm_pkg::result_t model(input logic m0, input logic [59:0] w);
        norm_pkg::result_t r;
        logic [10:0] ex;
        logic [47:0] cf;
        logic [48:0] sh;
        logic [59:0] p;
        int c;
        r = '0;
        ex = w[58:48] ^ {11{w[59]}};
        cf = w[47:0] ^ {48{w[59]}};
        c = 48;
        for (int i = 0; i < 48; i++) if (cf[i]) c = 47 - i;
        r.sign_ctl = w[59];
        if (&ex[9:0]) begin
            r.result = w;
            r.indefinite = ~ex[10];
            r.infinite = ex[10];
        end else begin
            r.count = 18'(c);
            sh = {cf, m0} << c;
            p = {1'b0, ex - 11'(c), sh[48:1]};
            if (int'(ex) < c || (cf == 48'h0 && !m0)) r.underflow = 1'b1;
            else r.result = w[59] ? ~p : p;
        end
        return r;
    endfunction
    // One launch, held back for hold cycles, judged three cycles after it is taken
    task automatic launch_chk(input logic m0v, input logic [59:0] w, input int hold);
        norm_pkg::result_t e;
        e = model(m0v, w);
        @(posedge clk_sys);
        issue <= 1'b1;
        m0_r <= m0v;
        word_r <= w;
        reserved <= (hold != 0);
        for (int i = 0; i < hold; i++) begin
            @(posedge clk_sys);
            if (i == hold - 1) reserved <= 1'b0;
            #1 chk("held go", 1'b0, launch.go);
        end
        @(posedge clk_sys);
        issue <= 1'b0;
        #1 chk("go", 1'b1, launch.go);
        repeat (3) @(posedge clk_sys);
        #1 chk("result_we", 1'b1, res.result_we);
        chk("result", e.result, res.result);
        chk("count", e.count, res.count);
        chk("flags", {e.underflow, e.indefinite, e.infinite}, {res.underflow, res.indefinite, res.infinite});
        chk("sign_ctl", e.sign_ctl, res.sign_ctl);
        @(posedge clk_sys);
        #1 chk("result_we after", 1'b0, res.result_we);
        chk("result after", 60'h0, res.result);
        chk("count after", 18'h0_0000, res.count);
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask
    // Registers: reset value, refused launch, status after underflow, unmapped read
    task automatic reg_scn();
        bus_rd(norm_pkg::CTRL_OFS, 32'h0000_0001, "ctrl reset");
        bus_wr(norm_pkg::CTRL_OFS, 32'h0000_0000);
        @(posedge clk_sys);
        issue <= 1'b1;
        @(posedge clk_sys);
        issue <= 1'b0;
        repeat (6) begin
            @(posedge clk_sys);
            #1 chk("refused result_we", 1'b0, res.result_we);
        end
        bus_wr(norm_pkg::CTRL_OFS, 32'h0000_0001);
        launch_chk(1'b0, 60'h005_0000_0000_0001, 0);
        bus_rd(norm_pkg::STATUS_OFS, 32'h0000_0004, "status");
        bus_rd(norm_pkg::COUNT_OFS, 32'h0000_002F, "count reg");
        bus_rd(8'h0C, 32'h0000_0000, "unmapped");
        $display("register test done");
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        foreach (vec[i]) launch_chk(vec[i][60], vec[i][59:0], 0);
        $display("operand table done");
        launch_chk(1'b0, 60'h400_0000_0000_1234, 2);
        $display("reservation test done");
        reg_scn();
        tally_and_finish();
    end
endmodule
`default_nettype wire
